// ==== sim/tcc2_core_test.sv ====
// Self-checking testbench of the timer core.
// Assumes tcc2_params.svh, the core and the pin source model.
`timescale 1ns/1ns
`default_nettype none
`include "tcc2_params.svh"
module tcc2_core_test;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [19:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, pin_a, pin_b, irq_a, irq_b, irq_p, irq_d;
   logic out_a, out_b, err, o;
   logic [31:0] rd, c;
   int error_cnt = 0;
   int checks = 0;
   int n_a = 0;
   int n_p = 0;
   int n_d = 0;
   int n_b = 0;
   int p, d, a, b;
   always #5 mclk_i = ~mclk_i;
   tcc2_core tcc2_core_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o),
      .ext_irq_pin_a_i(pin_a), .ext_irq_pin_b_i(pin_b),
      .ext_irq_pin_a_o(irq_a), .ext_irq_pin_b_o(irq_b),
      .compare_primary_irq_o(irq_p), .compare_dual_irq_o(irq_d),
      .timer_out_a_o(out_a), .timer_out_b_o(out_b));
   tcc2_pin_src tcc2_pin_src_inst (.mclk_i(mclk_i), .pin_a_o(pin_a),
      .pin_b_o(pin_b));
   // One-cycle pulses are counted here so scenarios never miss them.
   always @(posedge mclk_i) begin
      if (irq_a === 1'b1) n_a++;
      if (irq_b === 1'b1) n_b++;
      if (irq_p === 1'b1) n_p++;
      if (irq_d === 1'b1) n_d++;
   end
   // ==========================================================
   // Shared tasks
   // ==========================================================
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [19:0] ad,
         input logic [31:0] dt);
      int n;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= ad;
      pwdata_i <= dt;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge mclk_i);
         if (pready_o === 1'b1) break;
      end
      chk({31'h0, n < 20}, 32'h1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [19:0] ad, input logic [31:0] dt);
      apb(1'b1, ad, dt);
   endtask
   task automatic rdc(input logic [19:0] ad, input logic [31:0] exp);
      apb(1'b0, ad, 32'h0);
      chk(rd, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic ev(input logic sel_b, input int k);
      repeat (k) tcc2_pin_src_inst.pulse(sel_b);
      idle(4);
   endtask
   task automatic poll_ovf;
      int n;
      for (n = 0; n < 1000; n++) begin
         apb(1'b0, `TCC2_A_CTRL, 32'h0);
         if (rd[6] === 1'b1) break;
      end
      chk({31'h0, rd[6]}, 32'h1);
   endtask
   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_reset;
      rdc(`TCC2_A_CTRL, 32'h0);
      rdc(`TCC2_A_COUNT, 32'h0);
      rdc(`TCC2_A_PRESC, 32'h11);
      rdc(`TCC2_A_CCC, 32'h10);
      rdc(`TCC2_A_OUTC, 32'h0);
      apb(1'b0, 20'h00000, 32'h0);
      chk({31'h0, err}, 32'h1);
      wr(`TCC2_A_COUNT, 32'h55);
      rdc(`TCC2_A_COUNT, 32'h0);
      wr(`TCC2_A_OUTC, 32'ha0);
      idle(3);
      chk({30'h0, out_a, out_b}, 32'h3);
      wr(`TCC2_A_OUTC, 32'h20);
      idle(3);
      chk({30'h0, out_a, out_b}, 32'h2);
      $display("test reset done");
   endtask
   task automatic t_event;
      wr(`TCC2_A_PRESC, 32'h91);
      wr(`TCC2_A_EDGE, 32'h05);
      wr(`TCC2_A_CMP0, 32'h2);
      wr(`TCC2_A_DUAL, 32'h4);
      wr(`TCC2_A_CCC, 32'h02);
      wr(`TCC2_A_OUTC, 32'h10);
      wr(`TCC2_A_CTRL, 32'h80);
      idle(3);
      o = out_a;
      p = n_p;
      d = n_d;
      b = n_b;
      ev(1'b1, 3);
      chk(32'(n_b - b), 32'h3);
      rdc(`TCC2_A_COUNT, 32'h2);
      chk(32'(n_p - p), 32'h1);
      chk({31'h0, out_a ^ o}, 32'h1);
      ev(1'b1, 2);
      rdc(`TCC2_A_COUNT, 32'h4);
      chk(32'(n_d - d), 32'h1);
      ev(1'b1, 1);
      rdc(`TCC2_A_COUNT, 32'h0);
      $display("test event count done");
   endtask
   task automatic t_capture;
      ev(1'b1, 2);
      a = n_a;
      ev(1'b0, 1);
      chk(32'(n_a - a), 32'h1);
      rdc(`TCC2_A_CAP, 32'h2);
      wr(`TCC2_A_CCC, 32'h01);
      ev(1'b1, 1);
      apb(1'b0, `TCC2_A_DUAL, 32'h0);
      chk({31'h0, rd === 32'h2 || rd === 32'h3}, 32'h1);
      apb(1'b0, `TCC2_A_COUNT, 32'h0);
      c = rd;
      wr(`TCC2_A_CTRL, 32'h80);
      rdc(`TCC2_A_COUNT, c);
      // A capture clear on pin a, then one count clock on pin b: the
      // counter passes one above the captured value and trips a compare.
      wr(`TCC2_A_CMP0, 32'h4);
      wr(`TCC2_A_CCC, 32'h05);
      p = n_p;
      ev(1'b0, 1);
      rdc(`TCC2_A_CAP, 32'h3);
      rdc(`TCC2_A_COUNT, 32'h3);
      ev(1'b1, 1);
      rdc(`TCC2_A_COUNT, 32'h0);
      chk(32'(n_p - p), 32'h1);
      wr(`TCC2_A_CTRL, 32'h00);
      rdc(`TCC2_A_COUNT, 32'h0);
      wr(`TCC2_A_EDGE, 32'h06);
      a = n_a;
      ev(1'b0, 1);
      rdc(`TCC2_A_CAP, 32'h3);
      chk(32'(n_a - a), 32'h2);
      $display("test capture done");
   endtask
   task automatic t_overflow;
      // The count clock is mclk divided by eight, slow enough to read.
      wr(`TCC2_A_PRESC, 32'h01);
      wr(`TCC2_A_CCC, 32'h10);
      wr(`TCC2_A_CTRL, 32'h80);
      poll_ovf;
      apb(1'b0, `TCC2_A_COUNT, 32'h0);
      chk({31'h0, rd < 32'h20}, 32'h1);
      idle(200);
      chk({31'h0, out_a}, 32'h0);
      rdc(`TCC2_A_CTRL, 32'hc0);
      wr(`TCC2_A_CTRL, 32'h80);
      rdc(`TCC2_A_CTRL, 32'h80);
      wr(`TCC2_A_CTRL, 32'h00);
      wr(`TCC2_A_CTRL, 32'ha0);
      poll_ovf;
      rdc(`TCC2_A_COUNT, 32'hff);
      idle(100);
      rdc(`TCC2_A_COUNT, 32'hff);
      wr(`TCC2_A_CTRL, 32'ha0);
      apb(1'b0, `TCC2_A_COUNT, 32'h0);
      chk({31'h0, rd <= 32'h1}, 32'h1);
      $display("test overflow done");
   endtask
   task automatic t_wide;
      wr(`TCC2_A_CTRL, 32'h10);
      wr(`TCC2_A_CMP0, 32'h1234);
      rdc(`TCC2_A_CMP0, 32'h1234);
      wr(`TCC2_A_DUAL, 32'hbeef);
      rdc(`TCC2_A_DUAL, 32'hbeef);
      $display("test wide mode done");
   endtask
   // ==========================================================
   // Sequence, watchdog and verdict
   // ==========================================================
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge mclk_i);
      rstn_i <= 1'b1;
      t_reset;
      t_event;
      t_capture;
      t_overflow;
      t_wide;
      stop_test;
   end
   // The whole run needs about 5000 cycles; this allows ten times that.
   initial begin
      #500000;
      error_cnt++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      stop_test;
   end
endmodule // tcc2_core_test
`default_nettype wire

// ==== sim/tcc2_pin_src.sv ====
// Partner model: the two external trigger pins of the timer core.
// Assumes the core samples the pins on rising edges of mclk_i.
`timescale 1ns/1ns
`default_nettype none
module tcc2_pin_src (
   input wire logic mclk_i,
   output logic pin_a_o,
   output logic pin_b_o
);
   initial begin
      pin_a_o = 1'b0;
      pin_b_o = 1'b0;
   end
   // ==========================================================
   // Pulse source
   // ==========================================================
   // Three clocks high and three low, so the two-flop synchroniser
   // never misses a level and each edge counts once.
   task automatic pulse(input logic sel_b);
      @(posedge mclk_i);
      if (sel_b) pin_b_o <= 1'b1;
      else pin_a_o <= 1'b1;
      repeat (3) @(posedge mclk_i);
      pin_a_o <= 1'b0;
      pin_b_o <= 1'b0;
      repeat (3) @(posedge mclk_i);
   endtask
endmodule // tcc2_pin_src
`default_nettype wire

// ==== src/tcc2_core.sv ====
// Up-counting 8/16-bit timer with compare, capture/compare and capture.
// Assumes an APB master on mclk_i and pin inputs synchronous to mclk_i.
`timescale 1ns/1ns
`default_nettype none
`include "tcc2_params.svh"

// What this block does
// - Counter advances on prescaler-selected count clock.
// - Width bit picks 8 or 16 bits.
// - Enabling loads zero on first count clock.
// - Disabling zeroes counter, stops capture and match.
// - Rewriting enable as one changes nothing.
// - Normal mode wraps at all-ones, sets overflow.
// - Overflow set by hardware, cleared by software.
// - Mode bit picks free-run or one-shot.
// - One-shot holds full count until overflow cleared.
// - Reset zeroes counter, counting stopped.
// - Primary match raises interrupt and output signal.
// - Control register picks dual register's role.
// - Dual compare match: interrupt, output, optional clear.
// - Pin b edge captures into dual register.
// - Pin a edge captures into dedicated register.
// - Match clears zero counter on next count clock.
// - Control enables clears and picks output mode.
// - Edge detector makes interrupts, triggers, event clock.
// - Output stage toggles or pulse-generates on match.
// - Disabled outputs drive programmed fixed level.
// - Selector passes divided clock or external edges.
// - Capture clear first shows count plus one.
// - Registers act at 16 bits in wide mode.
module tcc2_core (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [19:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic ext_irq_pin_a_i,
   input wire logic ext_irq_pin_b_i,
   output logic ext_irq_pin_a_o,
   output logic ext_irq_pin_b_o,
   output logic compare_primary_irq_o,
   output logic compare_dual_irq_o,
   output logic timer_out_a_o,
   output logic timer_out_b_o
);
   import tcc2_pkg::*;

   // =======================================================
   // Helpers
   // =======================================================
   function automatic tcc2_word_t wmask(input logic bw);
      return bw ? `TCC2_MASK16 : `TCC2_MASK8;
   endfunction

   function automatic logic edge_hit(input logic [1:0] m,
                                     input logic r, input logic f);
      unique case (tcc2_edge_t'(m))
         TCC2_EDGE_FALL: return f;
         TCC2_EDGE_RISE: return r;
         TCC2_EDGE_BOTH, TCC2_EDGE_BOTH2: return r | f;
      endcase
   endfunction

   // =======================================================
   // State
   // =======================================================
   logic ce_ff, ovf_ff, oneshot_ff, bw_ff;
   logic [7:0] presc_ff, ccc_ff, outc_ff;
   logic [3:0] edge_ff;
   tcc2_word_t cnt_ff, cmp0_ff, dual_ff, cap_ff;
   logic [10:0] div_ff;
   logic [2:0] a_sync_ff, b_sync_ff;
   logic zero_pend_ff, ghost_pend_ff, ghost_ff;
   logic m0_prev_ff, m1_prev_ff;
   logic pready_ff;

   // =======================================================
   // APB decode
   // =======================================================
   logic acc, wr_en, mapped;
   logic [31:0] rd_data;
   logic wr_ctrl, ce_clr_wr, ovf_sw_clr;
   tcc2_word_t mask, mx;

   assign mask = wmask(bw_ff);
   assign mx = mask;
   assign acc = psel_i & penable_i;
   assign wr_en = acc & pwrite_i & pready_ff;
   assign wr_ctrl = wr_en & (paddr_i == `TCC2_A_CTRL);
   assign ce_clr_wr = wr_ctrl & ~pwdata_i[`TCC2_B_CE];
   assign ovf_sw_clr = wr_ctrl & ~pwdata_i[`TCC2_B_OVF] & ovf_ff;

   always_comb begin
      mapped = 1'b1;
      rd_data = 32'h0000_0000;
      unique case (paddr_i)
         `TCC2_A_CTRL: rd_data[7:4] = {ce_ff, ovf_ff, oneshot_ff, bw_ff};
         `TCC2_A_COUNT: rd_data[15:0] = cnt_ff & mask;
         `TCC2_A_CMP0: rd_data[15:0] = cmp0_ff & mask;
         `TCC2_A_DUAL: rd_data[15:0] = dual_ff & mask;
         `TCC2_A_CAP: rd_data[15:0] = cap_ff & mask;
         `TCC2_A_PRESC: rd_data[7:0] = presc_ff;
         `TCC2_A_CCC: rd_data[7:0] = ccc_ff;
         `TCC2_A_OUTC: rd_data[7:0] = outc_ff;
         `TCC2_A_EDGE: rd_data[3:0] = edge_ff;
         default: mapped = 1'b0;
      endcase
   end

   // One wait state keeps every bus output on a flip-flop.
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pready_ff <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_ff <= acc & ~pready_ff;
         prdata_o <= (acc & ~pready_ff & ~pwrite_i) ? rd_data : 32'h0;
         pslverr_o <= acc & ~pready_ff & ~mapped;
      end
   end
   assign pready_o = pready_ff;

   // =======================================================
   // Pin synchronisers and edge detection
   // =======================================================
   logic a_rise, a_fall, b_rise, b_fall, edge_a, edge_b;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         a_sync_ff <= 3'h0;
         b_sync_ff <= 3'h0;
      end else begin
         a_sync_ff <= {a_sync_ff[1:0], ext_irq_pin_a_i};
         b_sync_ff <= {b_sync_ff[1:0], ext_irq_pin_b_i};
      end
   end
   assign a_rise = a_sync_ff[1] & ~a_sync_ff[2];
   assign a_fall = ~a_sync_ff[1] & a_sync_ff[2];
   assign b_rise = b_sync_ff[1] & ~b_sync_ff[2];
   assign b_fall = ~b_sync_ff[1] & b_sync_ff[2];
   assign edge_a = edge_hit(edge_ff[1:0], a_rise, a_fall);
   assign edge_b = edge_hit(edge_ff[3:2], b_rise, b_fall);

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ext_irq_pin_a_o <= 1'b0;
         ext_irq_pin_b_o <= 1'b0;
      end else begin
         ext_irq_pin_a_o <= edge_a;
         ext_irq_pin_b_o <= edge_b;
      end
   end

   // =======================================================
   // Prescaler and count clock selector
   // =======================================================
   logic [3:0] sel;
   logic [10:0] dmask;
   logic cnt_clk, tick;

   assign sel = presc_ff[7:4];
   // A code of n divides by 8 << n; codes above eight count pin b.
   assign dmask = 11'h7ff >> (`TCC2_SEL_MAXINT - sel);
   assign cnt_clk = (sel <= `TCC2_SEL_MAXINT) ? &(div_ff | ~dmask)
                                              : edge_b;
   assign tick = ce_ff & cnt_clk;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) div_ff <= 11'h000;
      else div_ff <= div_ff + 11'h001;
   end

   // =======================================================
   // Compare, capture and clear sources
   // =======================================================
   logic dual_cap, m0, m1, m0_new, m1_new, cap_a, cap_b;
   logic cap_clr, mclr, restart, ovf_set;

   assign dual_cap = ccc_ff[`TCC2_B_DUALCAP];
   assign m0 = ce_ff & (cnt_ff == (cmp0_ff & mask));
   assign m1 = ce_ff & ~dual_cap & (cnt_ff == (dual_ff & mask));
   assign m0_new = m0 & ~m0_prev_ff;
   assign m1_new = m1 & ~m1_prev_ff;
   assign cap_a = ce_ff & edge_a;
   assign cap_b = ce_ff & dual_cap & edge_b;
   assign cap_clr = (cap_a & ccc_ff[`TCC2_B_CLRCAP]) |
                    (cap_b & ccc_ff[`TCC2_B_CLRDUAL]);
   assign mclr = (m1_new & ccc_ff[`TCC2_B_CLRDUAL]) |
                 (m0_new & ccc_ff[`TCC2_B_CLRPRI]);
   // A pending match clear that lands on all-ones is still a wrap.
   assign ovf_set = tick & ~ghost_pend_ff & ~ghost_ff &
                    (oneshot_ff ? (~zero_pend_ff & (cnt_ff == mx - 16'h0001))
                                : (cnt_ff == mx));
   assign restart = tick & ~ghost_pend_ff &
                    (zero_pend_ff | (~oneshot_ff & (cnt_ff == mx)));

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         m0_prev_ff <= 1'b0;
         m1_prev_ff <= 1'b0;
         compare_primary_irq_o <= 1'b0;
         compare_dual_irq_o <= 1'b0;
      end else begin
         m0_prev_ff <= m0;
         m1_prev_ff <= m1;
         compare_primary_irq_o <= m0_new;
         compare_dual_irq_o <= m1_new;
      end
   end

   // =======================================================
   // Control register
   // =======================================================
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ce_ff <= 1'b0;
         oneshot_ff <= 1'b0;
         bw_ff <= 1'b0;
      end else if (wr_ctrl) begin
         ce_ff <= pwdata_i[`TCC2_B_CE];
         oneshot_ff <= pwdata_i[`TCC2_B_ONESHOT];
         bw_ff <= pwdata_i[`TCC2_B_BW];
      end
   end

   // Writing one never sets the flag; a new overflow beats a clear.
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) ovf_ff <= 1'b0;
      else if (ovf_set) ovf_ff <= 1'b1;
      else if (ovf_sw_clr) ovf_ff <= 1'b0;
   end

   // =======================================================
   // Counter
   // =======================================================
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         zero_pend_ff <= 1'b0;
         ghost_pend_ff <= 1'b0;
         ghost_ff <= 1'b0;
      end else begin
         ghost_ff <= tick & ghost_pend_ff & ~ce_clr_wr;
         if (!ce_ff || ce_clr_wr) begin
            // a start only arms when the enable was clear.
            zero_pend_ff <= wr_ctrl & pwdata_i[`TCC2_B_CE] & ~ce_ff;
            ghost_pend_ff <= 1'b0;
         end else begin
            if (mclr) zero_pend_ff <= 1'b1;
            else if (tick) zero_pend_ff <= 1'b0;
            if (cap_clr) ghost_pend_ff <= 1'b1;
            else if (tick) ghost_pend_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) cnt_ff <= 16'h0000;
      else if (!ce_ff || ce_clr_wr) cnt_ff <= 16'h0000;
      else if (ghost_ff) cnt_ff <= 16'h0000;
      else if (ovf_sw_clr && oneshot_ff) cnt_ff <= 16'h0000;
      else if (tick) begin
         if (ghost_pend_ff) cnt_ff <= (cnt_ff + 16'h0001) & mask;
         else if (zero_pend_ff) cnt_ff <= 16'h0000;
         else if (cnt_ff == mx) cnt_ff <= oneshot_ff ? cnt_ff
                                                     : 16'h0000;
         else cnt_ff <= (cnt_ff + 16'h0001) & mask;
      end
   end

   // =======================================================
   // Compare, capture and configuration registers
   // =======================================================
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cmp0_ff <= 16'h0000;
         dual_ff <= 16'h0000;
         cap_ff <= 16'h0000;
      end else begin
         if (wr_en && paddr_i == `TCC2_A_CMP0) cmp0_ff <= pwdata_i[15:0];
         // A capture in the same cycle as a write keeps the capture.
         if (cap_b) dual_ff <= cnt_ff;
         else if (wr_en && paddr_i == `TCC2_A_DUAL)
            dual_ff <= pwdata_i[15:0];
         if (cap_a) cap_ff <= cnt_ff;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         presc_ff <= `TCC2_RST_PRESC;
         ccc_ff <= `TCC2_RST_CCC;
         outc_ff <= `TCC2_RST_ZERO;
         edge_ff <= 4'h0;
      end else if (wr_en) begin
         if (paddr_i == `TCC2_A_PRESC) presc_ff <= pwdata_i[7:0];
         if (paddr_i == `TCC2_A_CCC) ccc_ff <= pwdata_i[7:0];
         if (paddr_i == `TCC2_A_OUTC) outc_ff <= pwdata_i[7:0];
         if (paddr_i == `TCC2_A_EDGE) edge_ff <= pwdata_i[3:0];
      end
   end

   // =======================================================
   // Output control stage
   // =======================================================
   logic pulse_generator_output;
   assign pulse_generator_output = ccc_ff[`TCC2_B_PPG];

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         timer_out_a_o <= 1'b0;
         timer_out_b_o <= 1'b0;
      end else begin
         if (!outc_ff[`TCC2_B_ENA]) timer_out_a_o <= outc_ff[`TCC2_B_LVLA];
         else if (pulse_generator_output && m0_new) timer_out_a_o <= 1'b0;
         else if (pulse_generator_output && restart) timer_out_a_o <= 1'b1;
         else if (!pulse_generator_output && m0_new) timer_out_a_o <= ~timer_out_a_o;
         if (!outc_ff[`TCC2_B_ENB]) timer_out_b_o <= outc_ff[`TCC2_B_LVLB];
         else if (pulse_generator_output && m1_new) timer_out_b_o <= 1'b0;
         else if (pulse_generator_output && restart) timer_out_b_o <= 1'b1;
         else if (!pulse_generator_output && m1_new) timer_out_b_o <= ~timer_out_b_o;
      end
   end

   // =======================================================
   // Assertions
   // =======================================================
   property p_stop_zero;
      @(posedge mclk_i) disable iff (!rstn_i)
      $fell(ce_ff) |-> (cnt_ff == 16'h0000);
   endproperty
   a_stop_zero: assert property (p_stop_zero)
      else $error("counter not zero after stop");

   property p_wrap;
      @(posedge mclk_i) disable iff (!rstn_i)
      (tick && !oneshot_ff && cnt_ff == mx && !ghost_pend_ff &&
       !ghost_ff && !ce_clr_wr) |=> (cnt_ff == 16'h0000) && ovf_ff;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("wrap did not zero counter and flag overflow");

   property p_hold;
      @(posedge mclk_i) disable iff (!rstn_i)
      (ce_ff && oneshot_ff && ovf_ff && cnt_ff == mx && !wr_ctrl &&
       !ghost_ff && !ghost_pend_ff && !zero_pend_ff) |=> $stable(cnt_ff);
   endproperty
   a_hold: assert property (p_hold)
      else $error("one-shot counter left full count");

   property p_ovf_clear;
      @(posedge mclk_i) disable iff (!rstn_i)
      $fell(ovf_ff) |-> $past(ovf_sw_clr);
   endproperty
   a_ovf_clear: assert property (p_ovf_clear)
      else $error("overflow cleared without software write");

   property p_irq0;
      @(posedge mclk_i) disable iff (!rstn_i)
      m0_new |=> compare_primary_irq_o ##1 !compare_primary_irq_o;
   endproperty
   a_irq0: assert property (p_irq0)
      else $error("primary match interrupt not a single pulse");

   property p_cap;
      @(posedge mclk_i) disable iff (!rstn_i)
      cap_a |=> (cap_ff == $past(cnt_ff));
   endproperty
   a_cap: assert property (p_cap)
      else $error("dedicated capture missed counter value");

   property p_clr_late;
      @(posedge mclk_i) disable iff (!rstn_i)
      (mclr && ce_ff && !tick && !wr_ctrl && !ghost_ff) |=> $stable(cnt_ff);
   endproperty
   a_clr_late: assert property (p_clr_late)
      else $error("counter cleared before next count clock");

   property p_ghost;
      @(posedge mclk_i) disable iff (!rstn_i)
      (tick && ghost_pend_ff && !wr_ctrl) |=>
         (cnt_ff == (($past(cnt_ff) + 16'h0001) & mask)) ##1
         (cnt_ff == 16'h0000);
   endproperty
   a_ghost: assert property (p_ghost)
      else $error("capture clear did not pass through count plus one");

   property p_fixed;
      @(posedge mclk_i) disable iff (!rstn_i)
      !outc_ff[`TCC2_B_ENA] |=> (timer_out_a_o == $past(outc_ff[`TCC2_B_LVLA]));
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("disabled output not at fixed level");
endmodule // tcc2_core
`default_nettype wire

// ==== src/tcc2_params.svh ====
// Offsets, field positions, reset values and counts of the timer core.
// Assumes a 20-bit APB byte address and 32-bit data.
`ifndef TCC2_PARAMS_SVH
`define TCC2_PARAMS_SVH
// ==========================================================
// Register indices and byte addresses
// ==========================================================
`define TCC2_CTRL_IDX 18'h0ff5f
`define TCC2_A_CTRL 20'h3fd7c
`define TCC2_A_COUNT 20'h3fd80
`define TCC2_A_CMP0 20'h3fd84
`define TCC2_A_DUAL 20'h3fd88
`define TCC2_A_CAP 20'h3fd8c
`define TCC2_A_PRESC 20'h3fd90
`define TCC2_A_CCC 20'h3fd94
`define TCC2_A_OUTC 20'h3fd98
`define TCC2_A_EDGE 20'h3fd9c
// ==========================================================
// Fields and reset values
// ==========================================================
`define TCC2_B_CE 7
`define TCC2_B_OVF 6
`define TCC2_B_ONESHOT 5
`define TCC2_B_BW 4
`define TCC2_B_DUALCAP 0
`define TCC2_B_CLRDUAL 1
`define TCC2_B_CLRCAP 2
`define TCC2_B_CLRPRI 3
`define TCC2_B_PPG 4
`define TCC2_B_ENA 4
`define TCC2_B_LVLA 5
`define TCC2_B_ENB 6
`define TCC2_B_LVLB 7
`define TCC2_RST_PRESC 8'h11
`define TCC2_RST_CCC 8'h10
`define TCC2_RST_ZERO 8'h00
`define TCC2_SEL_MAXINT 4'h8
`define TCC2_MASK8 16'h00ff
`define TCC2_MASK16 16'hffff
`endif

// ==== src/tcc2_pkg.sv ====
// Types shared by the timer core.
// Assumes tcc2_params.svh for numeric constants.
package tcc2_pkg;
   typedef enum logic [1:0] {
      TCC2_EDGE_FALL = 2'h0,
      TCC2_EDGE_RISE = 2'h1,
      TCC2_EDGE_BOTH = 2'h2,
      TCC2_EDGE_BOTH2 = 2'h3
   } tcc2_edge_t;
   typedef logic [15:0] tcc2_word_t;
endpackage
